// ### design/twdbg_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module twdbg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; occupancy guards every read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// ### design/twdbg_port.sv
// Two-wire debug port: entry, bit shifting, framing, lock byte gating
`timescale 1ns/1ns
module twdbg_port #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        reset_n_pin,
    input  wire logic        debug_clock_pin,
    input  wire logic        debug_data_pin_in,
    output logic             debug_data_pin_out,
    output logic             debug_data_pin_oe,
    input  wire logic        gpio_data_out,
    input  wire logic        gpio_data_oe,
    input  wire logic        gpio_clock_out,
    input  wire logic        gpio_clock_oe,
    output logic             debug_clock_pin_out,
    output logic             debug_clock_pin_oe,
    input  wire logic [2:0]  system_clock_divider,
    input  wire logic        deep_sleep_mode_two,
    input  wire logic        deep_sleep_mode_three,
    input  wire logic        osc_stable,
    input  wire logic [7:0]  flash_lock_byte,
    input  wire logic        erase_done,
    input  wire logic [7:0]  cmd_answer,
    input  wire logic        flash_wr_req,
    input  wire logic [14:0] flash_wr_addr,
    input  wire logic        flash_wr_info_page,
    output logic             flash_wr_allow,
    output logic             debug_mode,
    output logic             info_page_sel,
    output logic             mass_erase_start,
    output logic [7:0]       cmd_out_data,
    output logic             cmd_out_valid,
    input  wire logic        cmd_out_ready
);
    logic [2:0] clk_sync_q, dat_sync_q, rstn_sync_q;
    logic       entry_cnt_q, entry_cnt_d;
    logic       dbg_q, dbg_d;
    twdbg_pkg::twdbg_state_type st_q, st_d;
    logic [7:0] sh_q, sh_d, cmd_q, cmd_d, cfg_q, cfg_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] args_q, args_d;
    logic [7:0] lock_q, lock_d;
    logic       rep_lock_q, rep_lock_d, busy_q, busy_d;
    logic       tx_bit_q, tx_bit_d, lock_load_q, lock_load_d;
    logic       rise, fall, ddat, allowed, cpu_ctl, deep;
    logic [7:0] status, ans;
    logic       fifo_valid_in, fifo_ready;
    logic [14:0] prot_base;

    // Third stage only feeds the edge detector, never the first flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_sync_q  <= 3'h0;
            dat_sync_q  <= 3'h0;
            rstn_sync_q <= 3'h0;
        end else begin
            clk_sync_q  <= {clk_sync_q[1:0], debug_clock_pin};
            dat_sync_q  <= {dat_sync_q[1:0], debug_data_pin_in};
            rstn_sync_q <= {rstn_sync_q[1:0], reset_n_pin};
        end
    end
    assign ddat = dat_sync_q[1];
    assign rise = clk_sync_q[1] && !clk_sync_q[2];
    assign fall = !clk_sync_q[1] && clk_sync_q[2];
    assign deep = deep_sleep_mode_two || deep_sleep_mode_three;

    assign cpu_ctl = (cmd_q == twdbg_pkg::CMD_HALT) || (cmd_q == twdbg_pkg::CMD_RESUME)
        || (cmd_q[7:2] == twdbg_pkg::CMD_INJECT_TOP) || (cmd_q == twdbg_pkg::CMD_SINGLE_STEP)
        || (cmd_q[7:2] == twdbg_pkg::CMD_STEP_REPL_TOP);
    assign allowed = lock_q[twdbg_pkg::LOCK_DBG_BIT]
        || (cmd_q == twdbg_pkg::CMD_MASS_ERASE) || (cmd_q == twdbg_pkg::CMD_STATUS_READ)
        || (cmd_q == twdbg_pkg::CMD_IDENTITY);

    always_comb begin
        status = 8'h00;
        status[twdbg_pkg::ST_ERASE_BUSY_BIT] = busy_q;
        status[twdbg_pkg::ST_OSC_BIT]        = osc_stable;
        status[twdbg_pkg::ST_LOCK_BIT]       = rep_lock_q;
        if (cmd_q == twdbg_pkg::CMD_STATUS_READ) begin
            ans = status;
        end else if (cmd_q == twdbg_pkg::CMD_RD_CONFIG) begin
            ans = cfg_q;
        end else if (!allowed || (busy_q && cmd_q != twdbg_pkg::CMD_MASS_ERASE)) begin
            ans = twdbg_pkg::CMD_REJECT_ANSWER;
        end else if (cmd_q == twdbg_pkg::CMD_MASS_ERASE) begin
            ans = status;
        end else begin
            ans = cmd_answer;
        end
    end

    // Argument count by opcode; injected instructions carry yy bytes
    function automatic logic [1:0] arg_count(input logic [7:0] c);
        if (c[7:2] == twdbg_pkg::CMD_INJECT_TOP || c[7:2] == twdbg_pkg::CMD_STEP_REPL_TOP) begin
            arg_count = c[1:0];
        end else if (c == twdbg_pkg::CMD_WR_CONFIG) begin
            arg_count = 2'h1;
        end else if (c == twdbg_pkg::CMD_SET_BREAK) begin
            arg_count = 2'h3;
        end else begin
            arg_count = 2'h0;
        end
    endfunction

    always_comb begin
        dbg_d       = dbg_q;
        entry_cnt_d = entry_cnt_q;
        st_d        = st_q;
        sh_d        = sh_q;
        cmd_d       = cmd_q;
        cfg_d       = cfg_q;
        bit_d       = bit_q;
        args_d      = args_q;
        tx_bit_d    = tx_bit_q;
        busy_d      = busy_q && !erase_done;
        lock_d      = lock_q;
        rep_lock_d  = rep_lock_q;
        lock_load_d = 1'b0;
        fifo_valid_in    = 1'b0;
        mass_erase_start = 1'b0;
        if (!rstn_sync_q[1]) begin
            lock_load_d = 1'b1;
            if (rise) begin
                if (entry_cnt_q) begin
                    dbg_d = 1'b1;
                end
                entry_cnt_d = 1'b1;
            end
        end else begin
            entry_cnt_d = 1'b0;
        end
        if (lock_load_q) begin
            lock_d     = flash_lock_byte;
            rep_lock_d = flash_lock_byte[twdbg_pkg::LOCK_DBG_BIT];
        end
        // Held device reset also drops a frame cut short by the host
        if (deep || !rstn_sync_q[1]) begin
            st_d = twdbg_pkg::TWDBG_IDLE;
        end else if (dbg_q) begin
            case (st_q)
                twdbg_pkg::TWDBG_IDLE: begin
                    bit_d = 3'h0;
                    st_d  = twdbg_pkg::TWDBG_RXCMD;
                end
                twdbg_pkg::TWDBG_RXCMD, twdbg_pkg::TWDBG_RXARG: begin
                    if (fall) begin
                        sh_d  = {sh_q[6:0], ddat};
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            if (st_q == twdbg_pkg::TWDBG_RXCMD) begin
                                cmd_d  = {sh_q[6:0], ddat};
                                args_d = arg_count({sh_q[6:0], ddat});
                                st_d   = (arg_count({sh_q[6:0], ddat}) == 2'h0)
                                    ? twdbg_pkg::TWDBG_EXEC : twdbg_pkg::TWDBG_RXARG;
                            end else begin
                                if (cmd_q == twdbg_pkg::CMD_WR_CONFIG && allowed) begin
                                    cfg_d = {sh_q[6:0], ddat};
                                end
                                args_d = args_q - 2'h1;
                                st_d   = (args_q == 2'h1) ? twdbg_pkg::TWDBG_EXEC
                                    : twdbg_pkg::TWDBG_RXARG;
                            end
                        end
                    end
                end
                twdbg_pkg::TWDBG_EXEC: begin
                    sh_d  = ans;
                    bit_d = 3'h0;
                    // The host clock never waits, so a full queue drops the opcode
                    fifo_valid_in = fifo_ready;
                    if (cmd_q == twdbg_pkg::CMD_MASS_ERASE && !busy_q) begin
                        mass_erase_start = 1'b1;
                        busy_d = 1'b1;
                        lock_d = twdbg_pkg::LOCK_BYTE_ERASED;
                    end
                    if (cpu_ctl && allowed && !busy_q) begin
                        rep_lock_d = lock_q[twdbg_pkg::LOCK_DBG_BIT];
                    end
                    st_d     = twdbg_pkg::TWDBG_TX;
                    tx_bit_d = ans[7];
                end
                twdbg_pkg::TWDBG_TX: begin
                    if (rise) begin
                        tx_bit_d = sh_q[7];
                        sh_d     = {sh_q[6:0], 1'b0};
                    end
                    if (fall) begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_d = twdbg_pkg::TWDBG_RXCMD;
                        end
                    end
                end
                default: st_d = twdbg_pkg::TWDBG_IDLE;
            endcase
        end
        if (flash_wr_req && flash_wr_info_page && flash_wr_addr[9:0] == twdbg_pkg::INFO_LOCK_ADDR
            && flash_wr_allow) begin
            lock_d = lock_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dbg_q       <= 1'b0;
            entry_cnt_q <= 1'b0;
            st_q        <= twdbg_pkg::TWDBG_IDLE;
            sh_q        <= 8'h00;
            cmd_q       <= 8'h00;
            cfg_q       <= 8'h00;
            bit_q       <= 3'h0;
            args_q      <= 2'h0;
            tx_bit_q    <= 1'b0;
            busy_q      <= 1'b0;
            lock_q      <= twdbg_pkg::LOCK_BYTE_ERASED;
            rep_lock_q  <= 1'b1;
            lock_load_q <= 1'b1;
        end else begin
            dbg_q       <= dbg_d;
            entry_cnt_q <= entry_cnt_d;
            st_q        <= st_d;
            sh_q        <= sh_d;
            cmd_q       <= cmd_d;
            cfg_q       <= cfg_d;
            bit_q       <= bit_d;
            args_q      <= args_d;
            tx_bit_q    <= tx_bit_d;
            busy_q      <= busy_d;
            lock_q      <= lock_d;
            rep_lock_q  <= rep_lock_d;
            lock_load_q <= lock_load_d;
        end
    end

    // Protected span counted down from the top of flash
    always_comb begin
        case (lock_q[twdbg_pkg::LOCK_SIZE_MSB:twdbg_pkg::LOCK_SIZE_LSB])
            3'h0: prot_base = 15'h0000;
            3'h1: prot_base = 15'h2000;
            3'h2: prot_base = 15'h4000;
            3'h3: prot_base = 15'h6000;
            3'h4: prot_base = 15'h7000;
            3'h5: prot_base = 15'h7800;
            3'h6: prot_base = 15'h7C00;
            default: prot_base = 15'h7FFF;
        endcase
    end
    always_comb begin
        flash_wr_allow = 1'b1;
        if (flash_wr_info_page) begin
            flash_wr_allow = dbg_q && info_page_sel;
        end else if (lock_q[twdbg_pkg::LOCK_SIZE_MSB:twdbg_pkg::LOCK_SIZE_LSB]
                     != 3'h7 && flash_wr_addr >= prot_base) begin
            flash_wr_allow = 1'b0;
        end else if (flash_wr_addr <= twdbg_pkg::BOOT_PAGE_LAST
                     && (!lock_q[twdbg_pkg::LOCK_BOOT_BIT]
                         || lock_q[twdbg_pkg::LOCK_SIZE_MSB:twdbg_pkg::LOCK_SIZE_LSB]
                            == twdbg_pkg::LOCK_SIZE_ALL)) begin
            flash_wr_allow = 1'b0;
        end
    end

    twdbg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_data   (cmd_q),
        .in_valid  (fifo_valid_in && allowed && !busy_q),
        .in_ready  (fifo_ready),
        .out_data  (cmd_out_data),
        .out_valid (cmd_out_valid),
        .out_ready (cmd_out_ready)
    );

    assign debug_mode    = dbg_q;
    assign info_page_sel = cfg_q[twdbg_pkg::CFG_INFO_PAGE_BIT];
    assign debug_data_pin_out  = dbg_q ? tx_bit_q : gpio_data_out;
    assign debug_data_pin_oe   = dbg_q ? (st_q == twdbg_pkg::TWDBG_TX) : gpio_data_oe;
    assign debug_clock_pin_out = gpio_clock_out;
    assign debug_clock_pin_oe  = dbg_q ? 1'b0 : gpio_clock_oe;

    AST_NO_CLK_DRIVE: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_q |-> !debug_clock_pin_oe) else $error("clock pin driven in debug");
    AST_OE_ONLY_TX: assert property (@(posedge ref_clk) disable iff (rst)
        (dbg_q && st_q != twdbg_pkg::TWDBG_TX) |-> !debug_data_pin_oe)
        else $error("data pin driven early");
    AST_LOCKED_REJECT: assert property (@(posedge ref_clk) disable iff (rst)
        (st_q == twdbg_pkg::TWDBG_EXEC && !lock_q[twdbg_pkg::LOCK_DBG_BIT]
            && cmd_q == twdbg_pkg::CMD_HALT)
        |-> !u_cmd_fifo.push) else $error("locked command passed");
    AST_ERASE_UNLOCK: assert property (@(posedge ref_clk) disable iff (rst)
        mass_erase_start |=> lock_q == twdbg_pkg::LOCK_BYTE_ERASED) else $error("erase kept lock");
    AST_BOOT_PROT: assert property (@(posedge ref_clk) disable iff (rst)
        (!flash_wr_info_page && flash_wr_addr <= twdbg_pkg::BOOT_PAGE_LAST
            && !lock_q[twdbg_pkg::LOCK_BOOT_BIT])
        |-> !flash_wr_allow) else $error("boot page writable");
    AST_REP_STABLE: assert property (@(posedge ref_clk) disable iff (rst)
        (rep_lock_q != $past(rep_lock_q))
        |-> ($past(st_q) == twdbg_pkg::TWDBG_EXEC || $past(lock_load_q)))
        else $error("reported lock moved");
    AST_DEEP_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        deep |=> st_q == twdbg_pkg::TWDBG_IDLE) else $error("debug active in deep sleep");
    AST_GPIO_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        !dbg_q |-> debug_data_pin_oe == gpio_data_oe) else $error("gpio not passed");
endmodule

// ### include/twdbg_pkg.sv
// Constants and types shared by the two-wire debug port
package twdbg_pkg;
    localparam int          FLASH_SIZE_BYTES = 32768;
    localparam int          FLASH_ADDR_W     = 15;
    localparam logic [14:0] BOOT_PAGE_LAST   = 15'h03FF;
    localparam logic [7:0]  LOCK_BYTE_ERASED = 8'hFF;
    localparam logic [9:0]  INFO_LOCK_ADDR   = 10'h000;
    localparam int          LOCK_DBG_BIT     = 0;
    localparam int          LOCK_SIZE_LSB    = 1;
    localparam int          LOCK_SIZE_MSB    = 3;
    localparam int          LOCK_BOOT_BIT    = 4;
    localparam logic [2:0]  LOCK_SIZE_ALL    = 3'h0;
    localparam logic [7:0]  CMD_MASS_ERASE   = 8'h14;
    localparam logic [7:0]  CMD_WR_CONFIG    = 8'h1D;
    localparam logic [7:0]  CMD_RD_CONFIG    = 8'h24;
    localparam logic [7:0]  CMD_STATUS_READ  = 8'h34;
    localparam logic [7:0]  CMD_HALT         = 8'h44;
    localparam logic [7:0]  CMD_RESUME       = 8'h4C;
    localparam logic [5:0]  CMD_INJECT_TOP   = 6'h15;
    localparam logic [7:0]  CMD_SINGLE_STEP  = 8'h5C;
    localparam logic [5:0]  CMD_STEP_REPL_TOP = 6'h19;
    localparam logic [7:0]  CMD_IDENTITY     = 8'h68;
    localparam logic [7:0]  CMD_SET_BREAK    = 8'h3B;
    localparam int          CFG_INFO_PAGE_BIT = 3;
    localparam int          ST_ERASE_BUSY_BIT = 7;
    localparam int          ST_LOCK_BIT      = 2;
    localparam int          ST_OSC_BIT       = 6;
    localparam int          ENTRY_EDGES      = 2;
    localparam logic [2:0]  CLKDIV_MAX_OK    = 3'h1;
    localparam logic [7:0]  CMD_REJECT_ANSWER = 8'h00;
    typedef enum logic [4:0] {
        TWDBG_IDLE  = 5'b00001,
        TWDBG_RXCMD = 5'b00010,
        TWDBG_RXARG = 5'b00100,
        TWDBG_EXEC  = 5'b01000,
        TWDBG_TX    = 5'b10000
    } twdbg_state_type;
endpackage

// ### test/twdbg_host.sv
// Behavioural debug host driving reset, clock and data of the two-wire link
`timescale 1ns/1ns
module twdbg_host (
    input  wire logic ref_clk,
    input  wire logic data_wire,
    output logic      reset_n,
    output logic      dbg_clk,
    output logic      data_drv,
    output logic      sending
);
    // Eight ref_clk cycles per half gives the 64 ns link clock period
    localparam int HALF = 8;
    initial begin
        reset_n = 1'b1;
        dbg_clk = 1'b0;
        data_drv = 1'b0;
        sending = 1'b0;
    end
    task automatic half_wait();
        repeat (HALF) @(posedge ref_clk);
        #1;
    endtask
    // Clock stands low between frames
    task automatic enter();
        reset_n = 1'b0;
        half_wait();
        repeat (2) begin
            dbg_clk = 1'b1;
            half_wait();
            dbg_clk = 1'b0;
            half_wait();
        end
        reset_n = 1'b1;
        repeat (2) half_wait();
    endtask
    task automatic send(input logic [7:0] b, input logic last);
        sending = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            dbg_clk = 1'b1;
            data_drv = b[i];
            half_wait();
            dbg_clk = 1'b0;
            sending = !(last && i == 0);
            half_wait();
        end
    endtask
    // Released line toggles so a stale last bit can never pass for an answer
    task automatic recv(output logic [7:0] r);
        half_wait();
        for (int i = 7; i >= 0; i--) begin
            dbg_clk = 1'b1;
            data_drv = ~data_drv;
            half_wait();
            r[i] = data_wire;
            dbg_clk = 1'b0;
            half_wait();
        end
    endtask
endmodule

// ### test/twdbg_port_test.sv
// Self-checking bench for the two-wire debug port
`timescale 1ns/1ns
module twdbg_port_test;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        g_dout = 1'b0, g_doe = 1'b0, g_cout = 1'b0, g_coe = 1'b0;
    logic        osc = 1'b1, erase_done = 1'b0, wr_req = 1'b1, wr_info = 1'b0;
    logic [7:0]  lock = 8'hFE, answer = 8'hA5, ans;
    logic [14:0] wr_addr = 15'h0000;
    logic        out_ready = 1'b1, erase_seen = 1'b0, oe_clash = 1'b0, deep2 = 1'b0;
    wire logic   dev_out, dev_oe, clk_out, clk_oe, wr_allow, dbg_mode, info_sel;
    wire logic   erase_start, q_valid, reset_n, dbg_clk, drv, sending;
    wire logic [7:0] q_data;
    wire logic   data_wire = dev_oe ? dev_out : drv;
    int          n_errors = 0, checked = 0, pops;
    int          sizes [8] = '{32768, 24576, 16384, 8192, 4096, 2048, 1024, 0};
    always #2 ref_clk = ~ref_clk;
    twdbg_port #(.FIFO_DEPTH(16)) u_twdbg_port (.ref_clk(ref_clk), .rst(rst),
        .reset_n_pin(reset_n), .debug_clock_pin(dbg_clk), .debug_data_pin_in(data_wire),
        .debug_data_pin_out(dev_out), .debug_data_pin_oe(dev_oe), .gpio_data_out(g_dout),
        .gpio_data_oe(g_doe), .gpio_clock_out(g_cout), .gpio_clock_oe(g_coe),
        .debug_clock_pin_out(clk_out), .debug_clock_pin_oe(clk_oe),
        .system_clock_divider(3'h0),
        .deep_sleep_mode_two(deep2), .deep_sleep_mode_three(1'b0),
        .osc_stable(osc), .flash_lock_byte(lock), .erase_done(erase_done), .cmd_answer(answer),
        .flash_wr_req(wr_req), .flash_wr_addr(wr_addr), .flash_wr_info_page(wr_info),
        .flash_wr_allow(wr_allow), .debug_mode(dbg_mode), .info_page_sel(info_sel),
        .mass_erase_start(erase_start), .cmd_out_data(q_data), .cmd_out_valid(q_valid),
        .cmd_out_ready(out_ready));
    twdbg_host u_twdbg_host (.ref_clk(ref_clk), .data_wire(data_wire), .reset_n(reset_n),
        .dbg_clk(dbg_clk), .data_drv(drv), .sending(sending));
    always @(posedge ref_clk) begin
        if (erase_start === 1'b1) erase_seen <= 1'b1;
        if (sending && dev_oe === 1'b1) oe_clash <= 1'b1;
    end
    task automatic conclude();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Command byte plus up to three argument bytes, then one returned byte
    task automatic cmd(input logic [31:0] bytes, input int n, output logic [7:0] r);
        for (int k = 0; k < n; k++) u_twdbg_host.send(bytes[31-8*k -: 8], k == n - 1);
        u_twdbg_host.recv(r);
        chk(oe_clash, 1'b0);
    endtask
    task automatic probe(input logic [14:0] a, input logic exp);
        @(posedge ref_clk);
        #1 wr_addr = a;
        #1 chk(wr_allow, exp);
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        $display("Error at %0t: run limit reached", $time);
        conclude();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        g_dout = 1'b1;
        g_doe = 1'b1;
        g_coe = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk({dev_out, dev_oe, clk_oe, dbg_mode}, 4'hE);
        g_doe = 1'b0;
        g_coe = 1'b0;
        u_twdbg_host.enter();
        chk({dbg_mode, clk_oe, dev_oe}, 3'h4);
        cmd({twdbg_pkg::CMD_STATUS_READ, 24'h0}, 1, ans);
        chk(ans & 8'hC4, 8'h40);
        cmd({twdbg_pkg::CMD_HALT, 24'h0}, 1, ans);
        chk(ans, twdbg_pkg::CMD_REJECT_ANSWER);
        answer = 8'h5A;
        cmd({twdbg_pkg::CMD_IDENTITY, 24'h0}, 1, ans);
        chk(ans, 8'h5A);
        cmd({twdbg_pkg::CMD_WR_CONFIG, 8'h08, 16'h0}, 2, ans);
        chk(info_sel, 1'b0);
        answer = 8'hA5;
        cmd({twdbg_pkg::CMD_MASS_ERASE, 24'h0}, 1, ans);
        chk(erase_seen, 1'b1);
        cmd({twdbg_pkg::CMD_STATUS_READ, 24'h0}, 1, ans);
        chk(ans & 8'h80, 8'h80);
        cmd({twdbg_pkg::CMD_HALT, 24'h0}, 1, ans);
        chk(ans, 8'h00);
        @(posedge ref_clk);
        #1 erase_done = 1'b1;
        @(posedge ref_clk);
        #1 erase_done = 1'b0;
        cmd({twdbg_pkg::CMD_STATUS_READ, 24'h0}, 1, ans);
        chk(ans & 8'h84, 8'h00);
        cmd({twdbg_pkg::CMD_HALT, 24'h0}, 1, ans);
        chk(ans, 8'hA5);
        cmd({twdbg_pkg::CMD_STATUS_READ, 24'h0}, 1, ans);
        chk(ans & 8'hC4, 8'h44);
        wr_info = 1'b1;
        probe(twdbg_pkg::INFO_LOCK_ADDR, 1'b0);
        cmd({twdbg_pkg::CMD_WR_CONFIG, 8'h08, 16'h0}, 2, ans);
        chk(info_sel, 1'b1);
        probe(twdbg_pkg::INFO_LOCK_ADDR, 1'b1);
        wr_info = 1'b0;
        // Fill the opcode queue with its reader stalled, then drain it
        out_ready = 1'b0;
        repeat (17) cmd({twdbg_pkg::CMD_HALT, 24'h0}, 1, ans);
        out_ready = 1'b1;
        pops = 0;
        repeat (64) begin
            @(negedge ref_clk);
            if (q_valid === 1'b1) begin
                pops++;
                chk(q_data, twdbg_pkg::CMD_HALT);
            end
        end
        chk(pops, 16);
        // A deep sleep pulse between frames must leave the link usable
        @(posedge ref_clk);
        #1 deep2 = 1'b1;
        @(posedge ref_clk);
        #1 deep2 = 1'b0;
        cmd({twdbg_pkg::CMD_STATUS_READ, 24'h0}, 1, ans);
        chk(ans & 8'h84, 8'h04);
        for (int c = 0; c < 8; c++) begin
            for (int b = 0; b < 2; b++) begin
                lock = {3'h0, b[0], c[2:0], 1'b1};
                u_twdbg_host.enter();
                probe(15'h7FFF, sizes[c] == 0);
                if (sizes[c] != 0 && sizes[c] != 32768) begin
                    probe(15'(32768 - sizes[c]), 1'b0);
                    probe(15'(32767 - sizes[c]), 1'b1);
                end
                probe(twdbg_pkg::BOOT_PAGE_LAST, b == 1 && c != 0);
            end
        end
        conclude();
    end
endmodule
